// *** design/codec_control_regs_two_to_four.sv ***
// control registers two to four reached over secondary serial frames
// Operation
// - reg two bit 5 reads decimator overflow; writes to it ignored.
// - reg two bit 4 set selects 16-bit capture, clear 15+1.
// - reg three write loads all eight bits; low six set sync delay.
// - reg three bits 7:6 hold the slave count, three at most.
// - reg four bits 3:2 select input gain: mute, 12, 6, 0 dB.
// - reg four bits 1:0 select output gain: mute, -12, -6, 0 dB.
// - reg four bits 6:4 set N; rate is mclk/(128N) or /(512N).
// - divisor output gives N, with zero meaning eight; reads return the code.
// - registers two, three, four reset to all zeros.
// - after reg three is written the codec uses its own slot.
// - frame bit 13 low means write, high means read.
// - frame bits 12:8 hold register number, 7:0 the data.
`timescale 1ns/100ps
module codec_control_regs_two_to_four
(
    // clock and reset
    input  wire logic       clk_sys_in,
    input  wire logic       rst_in,
    // serial port pins
    input  wire logic       sclk_in,
    input  wire logic       frame_sync_n_in,
    input  wire logic       din_in,
    output logic            dout_out,
    output logic            dout_oe_n_out,
    output logic            delayed_frame_sync_n_out,
    // status from the decimator and rate selection
    input  wire logic       decim_overflow_in,
    input  wire logic       oversample_512_in,
    // mode_and_flag_control
    output logic            flag_out,
    output logic            phone_mode_out,
    output logic            capture_16bit_out,
    output logic            analog_loopback_out,
    // sync_delay_control
    output logic [5:0]      sync_delay_out,
    output logic [1:0]      slave_count_out,
    output logic            slot_enable_out,
    // gain_and_rate_control
    output logic [1:0]      input_gain_out,
    output logic [1:0]      output_gain_out,
    output logic            pll_bypass_out,
    output logic [3:0]      divisor_n_out,
    output logic            sample_strobe_out
);
    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers: stage one feeds stage two only
    logic [2:0] sclk_q;
    logic [1:0] frm_sync_q;
    logic [1:0] din_q;

    always_ff @(posedge clk_sys_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            sclk_q     <= 3'h0;
            frm_sync_q <= 2'h3;
            din_q      <= 2'h0;
        end
        else
        begin
            sclk_q     <= {sclk_q[1:0], sclk_in};
            frm_sync_q <= {frm_sync_q[0], frame_sync_n_in};
            din_q      <= {din_q[0], din_in};
        end
    end

    logic sclk_rise;
    logic sclk_fall;
    logic frm_n_sync;
    logic din_sync;

    assign sclk_rise  = sclk_q[1] & ~sclk_q[2];
    assign sclk_fall  = ~sclk_q[1] & sclk_q[2];
    assign frm_n_sync = frm_sync_q[1];
    assign din_sync   = din_q[1];

    ////////////////////////////////////////////////////////////////////////
    // frame receiver: bits taken on falling sclk, msb first
    logic        in_frame_q;
    logic [4:0]  bit_cnt_q;
    logic [15:0] shift_q;
    logic [15:0] shift_d;
    logic        frame_start;
    logic        bit_take;
    logic        frame_done;
    logic        header_done;

    assign frame_start = sclk_fall & ~in_frame_q & ~frm_n_sync;
    assign bit_take    = sclk_fall & (in_frame_q | ~frm_n_sync);
    assign shift_d     = {shift_q[14:0], din_sync};
    assign frame_done  = bit_take &
        (bit_cnt_q == 5'(codec_ctrl_pkg::FRAME_BITS - 1));
    assign header_done = bit_take &
        (bit_cnt_q == 5'(codec_ctrl_pkg::HEADER_BITS - 1));

    always_ff @(posedge clk_sys_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            in_frame_q <= 1'b0;
            bit_cnt_q  <= 5'h00;
            shift_q    <= 16'h0000;
        end
        else if (bit_take)
        begin
            shift_q    <= shift_d;
            in_frame_q <= ~frame_done;
            bit_cnt_q  <= frame_done ? 5'h00 : bit_cnt_q + 5'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // decode of the received header and full frame
    logic [4:0] hdr_addr;
    logic       hdr_read;
    logic [4:0] frm_addr;
    logic       frm_write;
    logic [7:0] frm_data;

    assign hdr_addr  = shift_d[codec_ctrl_pkg::ADDR_MSB -
                               codec_ctrl_pkg::HEADER_BITS:0];
    assign hdr_read  = shift_d[codec_ctrl_pkg::RW_BIT -
                               codec_ctrl_pkg::HEADER_BITS];
    assign frm_addr  = shift_d[codec_ctrl_pkg::ADDR_MSB:
                               codec_ctrl_pkg::ADDR_LSB];
    assign frm_data  = shift_d[7:0];
    assign frm_write = frame_done & ~shift_d[codec_ctrl_pkg::RW_BIT];

    logic wr_mode;
    logic wr_sync;
    logic wr_gain;

    assign wr_mode = frm_write & (frm_addr == codec_ctrl_pkg::ADDR_MODE);
    assign wr_sync = frm_write & (frm_addr == codec_ctrl_pkg::ADDR_SYNC);
    assign wr_gain = frm_write & (frm_addr == codec_ctrl_pkg::ADDR_GAIN);

    ////////////////////////////////////////////////////////////////////////
    // register storage
    logic [7:0] mode_q;
    logic [7:0] sync_q;
    logic [7:0] gain_q;
    logic       slot_q;

    always_ff @(posedge clk_sys_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            mode_q <= codec_ctrl_pkg::MODE_RESET;
            sync_q <= codec_ctrl_pkg::SYNC_RESET;
            gain_q <= codec_ctrl_pkg::GAIN_RESET;
            slot_q <= 1'b0;
        end
        else
        begin
            if (wr_mode)
            begin
                mode_q <= frm_data &
                    ~(8'h01 << codec_ctrl_pkg::MODE_OVF_BIT);
            end
            if (wr_sync)
            begin
                sync_q <= frm_data;
            end
            if (wr_gain)
            begin
                gain_q <= frm_data;
            end
            if (wr_sync)
            begin
                slot_q <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read path: data byte returned in the same frame after the header
    logic [7:0] read_value;
    logic [7:0] mode_view;
    logic [7:0] tx_q;
    logic       tx_on_q;

    assign mode_view = mode_q |
        ({7'h00, decim_overflow_in} << codec_ctrl_pkg::MODE_OVF_BIT);
    assign read_value =
        (hdr_addr == codec_ctrl_pkg::ADDR_MODE) ? mode_view :
        (hdr_addr == codec_ctrl_pkg::ADDR_SYNC) ? sync_q :
        (hdr_addr == codec_ctrl_pkg::ADDR_GAIN) ? gain_q : 8'h00;

    // shifted out on rising sclk so the controller samples on falling
    always_ff @(posedge clk_sys_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            tx_q    <= 8'h00;
            tx_on_q <= 1'b0;
            dout_out <= 1'b0;
        end
        else if (header_done)
        begin
            tx_q    <= read_value;
            tx_on_q <= hdr_read;
        end
        else if (frame_done)
        begin
            tx_on_q <= 1'b0;
        end
        else if (sclk_rise & tx_on_q)
        begin
            dout_out <= tx_q[7];
            tx_q     <= {tx_q[6:0], 1'b0};
        end
    end

    assign dout_oe_n_out = ~tx_on_q;

    ////////////////////////////////////////////////////////////////////////
    // delayed frame sync, counted in sclks from frame start
    logic [5:0] dly_cnt_q;
    logic       dly_run_q;
    logic       dfs_n_q;
    logic [5:0] dly_field;

    assign dly_field = sync_q[codec_ctrl_pkg::SYNC_DLY_MSB:0];

    always_ff @(posedge clk_sys_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            dly_cnt_q <= 6'h00;
            dly_run_q <= 1'b0;
            dfs_n_q   <= 1'b1;
        end
        else if (frame_start)
        begin
            dly_cnt_q <= 6'h00;
            dly_run_q <= slot_q;
            dfs_n_q   <= 1'b1;
        end
        else if (sclk_rise & dly_run_q)
        begin
            dly_cnt_q <= dly_cnt_q + 6'h01;
            if (dly_cnt_q == dly_field)
            begin
                dfs_n_q   <= 1'b0;
                dly_run_q <= 1'b0;
            end
        end
        else if (sclk_rise)
        begin
            dfs_n_q <= 1'b1;
        end
    end

    assign delayed_frame_sync_n_out = dfs_n_q;

    ////////////////////////////////////////////////////////////////////////
    // field outputs
    // flag, phone, loopback, capture, then the sync and gain fields
    assign flag_out            = mode_q[codec_ctrl_pkg::MODE_FLAG_BIT];
    assign phone_mode_out      = mode_q[codec_ctrl_pkg::MODE_PHONE_BIT];
    assign analog_loopback_out = mode_q[codec_ctrl_pkg::MODE_ALB_BIT];
    assign capture_16bit_out   = mode_q[codec_ctrl_pkg::MODE_C16_BIT];
    assign sync_delay_out      = dly_field;
    assign slave_count_out     = sync_q[codec_ctrl_pkg::SYNC_SLV_MSB:
                                        codec_ctrl_pkg::SYNC_SLV_LSB];
    assign slot_enable_out     = slot_q;
    assign input_gain_out      = gain_q[codec_ctrl_pkg::GAIN_IN_MSB:
                                        codec_ctrl_pkg::GAIN_IN_LSB];
    assign output_gain_out     = gain_q[codec_ctrl_pkg::GAIN_OUT_MSB:
                                        codec_ctrl_pkg::GAIN_OUT_LSB];
    assign pll_bypass_out      = gain_q[codec_ctrl_pkg::GAIN_BYP_BIT];

    sample_rate_divider u_rate
    (
        .clk_sys_in        (clk_sys_in),
        .rst_in            (rst_in),
        .divisor_code_in   (gain_q[codec_ctrl_pkg::GAIN_N_MSB:
                                   codec_ctrl_pkg::GAIN_N_LSB]),
        .oversample_512_in (oversample_512_in),
        .divisor_n_out     (divisor_n_out),
        .sample_strobe_out (sample_strobe_out)
    );
endmodule // codec_control_regs_two_to_four

// *** design/codec_ctrl_pkg.sv ***
// shared constants for the codec control registers two to four
package codec_ctrl_pkg;
    // frame layout of a secondary serial frame, msb first
    localparam int unsigned FRAME_BITS   = 16;
    localparam int unsigned RW_BIT       = 13;
    localparam int unsigned ADDR_MSB     = 12;
    localparam int unsigned ADDR_LSB     = 8;
    localparam int unsigned HEADER_BITS  = 8;
    // register numbers
    localparam logic [4:0] ADDR_MODE     = 5'h02;
    localparam logic [4:0] ADDR_SYNC     = 5'h03;
    localparam logic [4:0] ADDR_GAIN     = 5'h04;
    // reset values
    localparam logic [7:0] MODE_RESET    = 8'h00;
    localparam logic [7:0] SYNC_RESET    = 8'h00;
    localparam logic [7:0] GAIN_RESET    = 8'h00;
    // mode_and_flag_control fields
    localparam int unsigned MODE_FLAG_BIT  = 7;
    localparam int unsigned MODE_PHONE_BIT = 6;
    localparam int unsigned MODE_OVF_BIT   = 5;
    localparam int unsigned MODE_C16_BIT   = 4;
    localparam int unsigned MODE_ALB_BIT   = 3;
    // sync_delay_control fields
    localparam int unsigned SYNC_DLY_MSB   = 5;
    localparam int unsigned SYNC_SLV_MSB   = 7;
    localparam int unsigned SYNC_SLV_LSB   = 6;
    localparam int unsigned DELAY_MIN      = 18;
    // gain_and_rate_control fields
    localparam int unsigned GAIN_BYP_BIT   = 7;
    localparam int unsigned GAIN_N_MSB     = 6;
    localparam int unsigned GAIN_N_LSB     = 4;
    localparam int unsigned GAIN_IN_MSB    = 3;
    localparam int unsigned GAIN_IN_LSB    = 2;
    localparam int unsigned GAIN_OUT_MSB   = 1;
    localparam int unsigned GAIN_OUT_LSB   = 0;
    // sample rate divider
    localparam int unsigned RATE_LOW_DIV   = 128;
    localparam int unsigned RATE_HIGH_DIV  = 512;
    localparam logic [3:0]  N_ZERO_CODE    = 4'h8;
endpackage

// *** design/sample_rate_divider.sv ***
// sample-rate strobe from the master clock, divided by 128*N or 512*N
`timescale 1ns/100ps
module sample_rate_divider
(
    // clock and reset
    input  wire logic       clk_sys_in,
    input  wire logic       rst_in,
    // control
    input  wire logic [2:0] divisor_code_in,
    input  wire logic       oversample_512_in,
    // result
    output logic [3:0]      divisor_n_out,
    output logic            sample_strobe_out
);
    logic [12:0] count_q;
    logic [12:0] count_d;
    logic [12:0] terminal;
    logic [3:0]  n_value;
    logic        strobe_d;

    assign n_value = (divisor_code_in == 3'h0) ? codec_ctrl_pkg::N_ZERO_CODE
                                               : {1'b0, divisor_code_in};
    assign terminal = oversample_512_in
        ? 13'(codec_ctrl_pkg::RATE_HIGH_DIV * n_value - 1)
        : 13'(codec_ctrl_pkg::RATE_LOW_DIV * n_value - 1);
    // a shrinking divisor must not strand the count above terminal
    assign strobe_d = (count_q >= terminal);
    assign count_d  = strobe_d ? 13'h0000 : count_q + 13'h0001;

    always_ff @(posedge clk_sys_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            count_q           <= 13'h0000;
            sample_strobe_out <= 1'b0;
            divisor_n_out     <= codec_ctrl_pkg::N_ZERO_CODE;
        end
        else
        begin
            count_q           <= count_d;
            sample_strobe_out <= strobe_d;
            divisor_n_out     <= n_value;
        end
    end
endmodule // sample_rate_divider

// *** dv/codec_ctrl_asserts.sv ***
// concurrent checks on the codec control register ports
`timescale 1ns/100ps
module codec_ctrl_asserts
(
    // clock and reset
    input  wire logic       clk_sys_in,
    input  wire logic       rst_in,
    // serial side
    input  wire logic       sclk_in,
    input  wire logic       dout_oe_n_out,
    input  wire logic       delayed_frame_sync_n_out,
    // register outputs
    input  wire logic       flag_out,
    input  wire logic       phone_mode_out,
    input  wire logic       capture_16bit_out,
    input  wire logic       analog_loopback_out,
    input  wire logic [5:0] sync_delay_out,
    input  wire logic [1:0] slave_count_out,
    input  wire logic       slot_enable_out,
    input  wire logic [1:0] input_gain_out,
    input  wire logic [1:0] output_gain_out,
    input  wire logic       pll_bypass_out,
    input  wire logic [3:0] divisor_n_out,
    input  wire logic       sample_strobe_out
);
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (rst_in);
    wire logic [16:0] cfg_w = {flag_out, phone_mode_out, capture_16bit_out,
        analog_loopback_out, slave_count_out, sync_delay_out,
        pll_bypass_out, input_gain_out, output_gain_out};
    ////////////////////////////////////////////////////////////////////////
    AST_RESET_CLEAR: assert property (
        $fell(rst_in) |-> cfg_w == 17'h0 && !slot_enable_out
            && divisor_n_out == 4'h8) else $error("bad reset state");
    AST_DIV_RANGE: assert property (
        divisor_n_out != 4'h0 && divisor_n_out <= 4'h8)
        else $error("divisor out of range");
    AST_STROBE_GAP: assert property (
        sample_strobe_out |=> !sample_strobe_out [*8])
        else $error("strobe too close");
    AST_SLOT_STICKY: assert property (
        slot_enable_out |=> slot_enable_out) else $error("slot dropped");
    AST_DFS_SLOT: assert property (
        !delayed_frame_sync_n_out |-> slot_enable_out)
        else $error("delayed sync without slot");
    AST_DFS_WIDTH: assert property (
        $fell(delayed_frame_sync_n_out) |=> !delayed_frame_sync_n_out [*5]
            ##[1:64] delayed_frame_sync_n_out) else $error("sync width");
    AST_OE_WIDTH: assert property (
        $fell(dout_oe_n_out) |=> !dout_oe_n_out [*8] ##[1:400] dout_oe_n_out)
        else $error("read enable width");
    // updates land only while the serial clock is low after a fall
    AST_CFG_SCLK_LOW: assert property (
        !$stable(cfg_w) |-> !sclk_in) else $error("update off frame");
    cover property (sample_strobe_out);
    cover property ($fell(delayed_frame_sync_n_out));
    cover property ($fell(dout_oe_n_out));
endmodule // codec_ctrl_asserts

bind codec_control_regs_two_to_four codec_ctrl_asserts codec_ctrl_asserts_i
(
    .clk_sys_in, .rst_in, .sclk_in, .dout_oe_n_out, .delayed_frame_sync_n_out,
    .flag_out, .phone_mode_out, .capture_16bit_out, .analog_loopback_out,
    .sync_delay_out, .slave_count_out, .slot_enable_out, .input_gain_out,
    .output_gain_out, .pll_bypass_out, .divisor_n_out, .sample_strobe_out
);

// *** dv/dsp_port_model.sv ***
// serial-port master model sending secondary frames to the codec
`timescale 1ns/100ps
module dsp_port_model
(
    // clock
    input  wire logic clk_sys_in,
    // codec pins
    input  wire logic dout_in,
    input  wire logic dout_oe_n_in,
    input  wire logic delayed_frame_sync_n_in,
    output logic      sclk_out,
    output logic      frame_sync_n_out,
    output logic      din_out
);
    int half = 6;
    int rises;
    int dfs_at;
    initial
    begin
        sclk_out = 1'b0;
        frame_sync_n_out = 1'b1;
        din_out = 1'b0;
    end
    task automatic frame(input logic [15:0] word, input int tail,
                         output logic [7:0] rdata);
        int i;
        rises = 0;
        dfs_at = -1;
        @(posedge clk_sys_in);
        frame_sync_n_out <= 1'b0;
        for (i = 0; i < 16 + tail; i++)
        begin
            @(posedge clk_sys_in);
            sclk_out <= 1'b1;
            // frame sync stays low across the first falling edge
            if (i == 1)
                frame_sync_n_out <= 1'b1;
            // idle data line toggles so stale bits cannot pass
            din_out <= (i < 16) ? word[15 - i] : ~din_out;
            rises++;
            repeat (half) @(posedge clk_sys_in);
            sclk_out <= 1'b0;
            if (i < 16)
                rdata = {rdata[6:0], dout_oe_n_in ? 1'bx : dout_in};
            if (!delayed_frame_sync_n_in && dfs_at < 0)
                dfs_at = rises;
            repeat (half - 1) @(posedge clk_sys_in);
        end
        @(posedge clk_sys_in);
        din_out <= ~din_out;
    endtask
endmodule // dsp_port_model

// *** dv/tb_top.sv ***
// self-checking bench for the codec control registers two to four
`timescale 1ns/100ps
module tb_top;
    logic       clk_sys_in = 1'b0;
    logic       rst_in = 1'b1;
    logic       decim_overflow_in = 1'b0;
    logic       oversample_512_in = 1'b0;
    logic       sclk_in, frame_sync_n_in, din_in, dout_out, dout_oe_n_out;
    logic       delayed_frame_sync_n_out, flag_out, phone_mode_out;
    logic       capture_16bit_out, analog_loopback_out, slot_enable_out;
    logic       pll_bypass_out, sample_strobe_out;
    logic [5:0] sync_delay_out;
    logic [1:0] slave_count_out, input_gain_out, output_gain_out;
    logic [3:0] divisor_n_out;
    int         mismatches = 0;
    int         checks = 0;
    int         seed = 32'h138e;
    int         regs [0:31] = '{default: 0};
    always #2 clk_sys_in = ~clk_sys_in;
    codec_control_regs_two_to_four codec_control_regs_two_to_four_i
    (
        .clk_sys_in, .rst_in, .sclk_in, .frame_sync_n_in, .din_in, .dout_out,
        .dout_oe_n_out, .delayed_frame_sync_n_out, .decim_overflow_in,
        .oversample_512_in, .flag_out, .phone_mode_out, .capture_16bit_out,
        .analog_loopback_out, .sync_delay_out, .slave_count_out,
        .slot_enable_out, .input_gain_out, .output_gain_out, .pll_bypass_out,
        .divisor_n_out, .sample_strobe_out
    );
    dsp_port_model dsp_port_model_i
    (
        .clk_sys_in, .dout_in(dout_out), .dout_oe_n_in(dout_oe_n_out),
        .delayed_frame_sync_n_in(delayed_frame_sync_n_out),
        .sclk_out(sclk_in), .frame_sync_n_out(frame_sync_n_in),
        .din_out(din_in)
    );
    ////////////////////////////////////////////////////////////////////////
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic check_pins;
        int n;
        n = (regs[4][6:4] == 0) ? 8 : regs[4][6:4];
        cmp({flag_out, phone_mode_out, analog_loopback_out},
            {regs[2][7], regs[2][6], regs[2][3]});
        cmp(capture_16bit_out, regs[2][4]);
        cmp({slave_count_out, sync_delay_out}, regs[3][7:0]);
        cmp({input_gain_out, output_gain_out}, regs[4][3:0]);
        cmp(pll_bypass_out, regs[4][7]);
        cmp(divisor_n_out, 16'(n));
    endtask
    task automatic wr(input int a, input int d);
        logic [7:0] r;
        dsp_port_model_i.frame({3'b000, a[4:0], d[7:0]}, 0, r);
        // overflow bit of register two is read-only
        if (a >= 2 && a <= 4)
            regs[a] = (a == 2) ? (d & 8'hDF) : d;
        repeat (4) @(negedge clk_sys_in);
        check_pins;
    endtask
    task automatic rd(input int a);
        logic [7:0] r;
        int e;
        dsp_port_model_i.frame({3'b001, a[4:0], 8'h00}, 0, r);
        e = (a >= 2 && a <= 4) ? regs[a] : 0;
        if (a == 2)
            e[5] = decim_overflow_in;
        cmp(r, e[7:0]);
    endtask
    task automatic period(input int os, input int code);
        int c;
        @(posedge clk_sys_in);
        oversample_512_in <= os[0];
        wr(4, code << 4);
        for (c = 0; c < 9000 && !sample_strobe_out; c++)
            @(negedge clk_sys_in);
        @(negedge clk_sys_in);
        for (c = 1; c < 9000 && !sample_strobe_out; c++)
            @(negedge clk_sys_in);
        cmp(c, 16'((os ? 512 : 128) * (code == 0 ? 8 : code)));
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial
    begin
        // register loop plus rate tests need well under this span
        repeat (90000) @(posedge clk_sys_in);
        mismatches++;
        end_of_test;
    end
    initial
    begin
        int i;
        int v;
        int d;
        repeat (3) @(posedge clk_sys_in);
        rst_in <= 1'b0;
        repeat (4) @(negedge clk_sys_in);
        check_pins;
        cmp(slot_enable_out, 1'b0);
        $display("reset test done");
        for (i = 0; i < 16; i++)
        begin
            v = $random(seed);
            d = 18 + (v[21:16] % 46);
            dsp_port_model_i.half = i[0] ? 9 : 6;
            @(posedge clk_sys_in);
            decim_overflow_in <= v[24];
            wr(2, {v[7:6], i[0], v[4:3], 3'b000});
            wr(4, {v[15], i[2:0], i[3:0]});
            wr(3, {i[1:0], d[5:0]});
            cmp(slot_enable_out, 1'b1);
            // unused register numbers must leave the bank alone
            wr(5 + i, v[23:16]);
            rd(2);
            rd(3);
            rd(4);
            rd((5 + 2 * i) % 32);
            dsp_port_model_i.frame(16'h0000, d, v[7:0]);
            // the model also counts the rise that opens the frame
            cmp(16'(dsp_port_model_i.dfs_at), 16'(d + 2));
        end
        $display("register test done");
        period(0, 1);
        period(1, 1);
        period(1, 0);
        period(0, 5);
        $display("rate test done");
        end_of_test;
    end
endmodule // tb_top
